// ==== rtl/fsm_failsafe_ctrl.sv ====
// Fail-safe / stand-alone mode controller with serial slave port.
// Assumes POR and OTP data from the chip; master drives the serial pins.
// Contract
// - Mode 000: controls clear at reset; failsafe only after mode write.
// - Mode 001: controls clear at reset as in mode 000; no failsafe entry.
// - Modes 000,001,110,111: reset pin fall resets device.
// - Modes 010..101: reset pin fall enters failsafe; pin enters and exits.
// - POR clears controls in every mode, 100/101 included; no OTP load.
// - Failsafe entry by pin reloads controls from OTP.
// - Modes 010,100,110 in failsafe or standalone ignore serial writes.
// - Invalid frames still set the serial error flag when writes blocked.
// - Modes 011,101,111 accept writes; writing 000/001 leaves failsafe.
// - Failsafe/standalone ignore LED pins; channels follow enable bits.
// - Modes 000/001 let LED pins gate channels with PWM.
// - Modes 110/111 enter standalone on reset pin rise after POR.
// - Device is slave only, never starts a transfer.
// - Single-device frames are 16 bits.
// - Response shifts out while command shifts in.
// - Chip select active low; data out released when unselected.
// - Drive on falling clock edge, sample on rising.
// - Star connection supported; daisy chain zero frame raises DAISY_CHAIN and SERIAL_ERROR_FLAG, SDO never forwards SDI.
// - Star after power-up; 16n zero bits switch to daisy chain.
// - Clock count not multiple of 16 flags framing error.
// - Mode latched on failsafe entry; cleared on POR or exit.
// - In failsafe pin no longer resets; rising edge exits.
`timescale 1ns/1ps
`default_nettype none
`include "fsm_params.svh"
module fsm_failsafe_ctrl #(
	parameter int CTRL_W = `FSM_CTRL_W
) (
	input wire logic CLK,
	input wire logic RST,
	input wire logic POR,
	input wire logic EXT_RESET_PIN_N,
	input wire logic OTP_LOCKED,
	input wire logic [CTRL_W-1:0] OTP_CTRL,
	input wire logic [1:0] LED_CONTROL_PIN,
	input wire logic SCLK,
	input wire logic CHIP_SELECT_N,
	input wire logic SDI,
	output logic SDO,
	output logic SDO_OE,
	output logic [CTRL_W-1:0] CTRL_REGS,
	output logic [1:0] BUCK_ON,
	output logic FAILSAFE_OPERATION,
	output logic STANDALONE_OPERATION,
	output logic SERIAL_ERROR_FLAG,
	output logic DAISY_CHAIN,
	output logic DEVICE_RESET
);
	// ==========================================
	// Synchronisers
	logic pin_s, led0_s, led1_s, tog_s;
	logic pin_d_reg, tog_d_reg;
	logic [15:0] rx_word;
	logic rx_err, rx_zero, rx_toggle, sdo_w, sdo_oe_w;
	fsm_sync u_pin (.clk(CLK), .d(EXT_RESET_PIN_N), .q(pin_s));
	fsm_sync u_led0 (.clk(CLK), .d(LED_CONTROL_PIN[0]), .q(led0_s));
	fsm_sync u_led1 (.clk(CLK), .d(LED_CONTROL_PIN[1]), .q(led1_s));
	fsm_sync u_tog (.clk(CLK), .d(rx_toggle), .q(tog_s));
	// ==========================================
	// State
	fsm_pkg::fsm_op_t op_reg, op_next;
	logic [CTRL_W-1:0] ctrl_reg, ctrl_next;
	logic [`FSM_MODE_W-1:0] latched_reg;
	logic err_reg, daisy_reg, rst_reg, last_ok_reg;
	logic [15:0] reply_reg;
	fsm_pkg::fsm_frame_t fr;
	wire logic [2:0] mode = ctrl_reg[`FSM_MODE_LSB +: 3];
	wire logic pin_fall = pin_d_reg & ~pin_s;
	wire logic pin_rise = ~pin_d_reg & pin_s;
	wire logic in_fso = (op_reg == fsm_pkg::ST_FAILSAFE);
	wire logic in_sa = (op_reg == fsm_pkg::ST_STANDALONE);
	wire logic [2:0] gov = in_fso ? latched_reg : mode;
	wire logic resetting_mode = (gov == `FSM_MODE_ZERO) || (gov == `FSM_MODE_OTP) || gov[2] & gov[1];
	wire logic wr_blocked = (in_fso | in_sa) & ~gov[0];
	wire logic par_ok = ^rx_word;
	wire logic frame_bad = fr.valid & (fr.frame_err | ~par_ok
		| (~rx_word[`FSM_CMD_BIT] & (rx_word[8:0] != 9'h000)));
	wire logic wr_ok = fr.valid & ~frame_bad & rx_word[`FSM_CMD_BIT] & ~wr_blocked
		& ~fr.daisy_req;
	wire logic [3:0] wr_addr = rx_word[14:11];
	wire logic [2:0] wr_mode = rx_word[`FSM_MODE_LSB +: 3];
	wire logic serial_exit = wr_ok & in_fso & (wr_addr == `FSM_ADDR_MODE)
		& (wr_mode[2:1] == 2'b00);
	assign fr.valid = tog_s ^ tog_d_reg;
	assign fr.word = rx_word;
	assign fr.frame_err = rx_err;
	assign fr.daisy_req = rx_zero & ~rx_err;
	// ==========================================
	// Next state
	always_comb
	begin
		op_next = op_reg;
		ctrl_next = ctrl_reg;
		if (in_fso & (pin_rise | serial_exit))
			op_next = fsm_pkg::ST_NORMAL;
		else if (pin_fall & ~in_fso & ~resetting_mode & OTP_LOCKED)
		begin
			op_next = fsm_pkg::ST_FAILSAFE;
			ctrl_next = OTP_CTRL;
		end
		if (wr_ok & ~(pin_fall & ~in_fso & ~resetting_mode & OTP_LOCKED))
		begin
			if (wr_addr == `FSM_ADDR_MODE)
				ctrl_next[`FSM_MODE_LSB +: 3] = wr_mode;
			else
				ctrl_next = rx_word[CTRL_W-1:0];
		end
	end
	// ==========================================
	// Registers
	always_ff @(posedge CLK)
	begin
		pin_d_reg <= pin_s;
		tog_d_reg <= tog_s;
		if (RST | POR | rst_reg)
		begin
			op_reg <= fsm_pkg::ST_NORMAL;
			latched_reg <= '0;
			err_reg <= 1'b0;
			daisy_reg <= 1'b0;
			last_ok_reg <= 1'b0;
			rst_reg <= 1'b0;
			reply_reg <= `FSM_ERR_REPLY;
			ctrl_reg <= '0;
		end
		else if (op_reg == fsm_pkg::ST_NORMAL && pin_rise && OTP_LOCKED && ctrl_reg == '0
			&& OTP_CTRL[`FSM_MODE_LSB + 2] & OTP_CTRL[`FSM_MODE_LSB + 1])
		begin
			op_reg <= fsm_pkg::ST_STANDALONE;
			ctrl_reg <= OTP_CTRL;
		end
		else
		begin
			op_reg <= op_next;
			ctrl_reg <= ctrl_next;
			if (op_next == fsm_pkg::ST_FAILSAFE && !in_fso)
				latched_reg <= mode;
			else if (op_next == fsm_pkg::ST_NORMAL && in_fso)
				latched_reg <= '0;
			rst_reg <= pin_fall & resetting_mode & ~in_fso;
			if (frame_bad)
				err_reg <= 1'b1;
			if (fr.valid & fr.daisy_req)
				daisy_reg <= 1'b1;
			if (fr.valid)
				last_ok_reg <= ~frame_bad;
			if (fr.valid)
				reply_reg <= frame_bad ? `FSM_ERR_REPLY : rx_word;
		end
	end
	// ==========================================
	// Power-on flag delayed one clock; nothing reads the delayed copy
	logic por_d_reg;
	always_ff @(posedge CLK)
	begin
		por_d_reg <= POR;
	end
	// ==========================================
	// Outputs
	wire logic pins_active = (op_next == fsm_pkg::ST_NORMAL);
	wire logic [1:0] en_bits = {ctrl_next[`FSM_BUCK1_BIT], ctrl_next[`FSM_BUCK2_BIT]};
	always_ff @(posedge CLK)
	begin
		if (RST | POR)
		begin
			BUCK_ON <= 2'b00;
			CTRL_REGS <= '0;
			FAILSAFE_OPERATION <= 1'b0;
			STANDALONE_OPERATION <= 1'b0;
			SERIAL_ERROR_FLAG <= 1'b0;
			DAISY_CHAIN <= 1'b0;
			DEVICE_RESET <= 1'b0;
		end
		else
		begin
			BUCK_ON <= pins_active ? (en_bits & {led1_s, led0_s}) : en_bits;
			CTRL_REGS <= ctrl_reg;
			FAILSAFE_OPERATION <= in_fso;
			STANDALONE_OPERATION <= in_sa;
			SERIAL_ERROR_FLAG <= err_reg;
			DAISY_CHAIN <= daisy_reg;
			DEVICE_RESET <= rst_reg;
		end
	end
	// ==========================================
	// Serial slave; it only answers, never initiates
	fsm_spi_slave u_spi (
		.sclk(SCLK),
		.cs_n(CHIP_SELECT_N),
		.sdi(SDI),
		.reply(reply_reg),
		.sdo(sdo_w),
		.sdo_oe(sdo_oe_w),
		.rx_word(rx_word),
		.rx_err(rx_err),
		.rx_zero(rx_zero),
		.rx_toggle(rx_toggle)
	);
	assign SDO = sdo_w;
	assign SDO_OE = sdo_oe_w;
	// ==========================================
	// Checks
	property p_fso_entry;
		@(posedge CLK) disable iff (RST | POR)
		(pin_fall & ~in_fso & ~resetting_mode & OTP_LOCKED & ~rst_reg) |=> in_fso && ctrl_reg == $past(OTP_CTRL);
	endproperty
	a_fso_entry: assert property (p_fso_entry) else $error("failsafe entry or reload missed");
	property p_reset_mode;
		@(posedge CLK) disable iff (RST | POR)
		(pin_fall & resetting_mode & ~in_fso & ~rst_reg) |=> rst_reg;
	endproperty
	a_reset_mode: assert property (p_reset_mode) else $error("pin fall did not reset");
	property p_no_reset_fso;
		@(posedge CLK) disable iff (RST | POR)
		in_fso |=> !rst_reg;
	endproperty
	a_no_reset_fso: assert property (p_no_reset_fso) else $error("reset while in failsafe");
	property p_blocked;
		@(posedge CLK) disable iff (RST | POR)
		(fr.valid & wr_blocked & ~pin_rise & ~pin_fall) |=> ctrl_reg == $past(ctrl_reg);
	endproperty
	a_blocked: assert property (p_blocked) else $error("write landed while blocked");
	property p_err;
		@(posedge CLK) disable iff (RST | POR)
		(frame_bad & ~rst_reg) |=> err_reg;
	endproperty
	a_err: assert property (p_err) else $error("error flag not set");
	property p_exit;
		@(posedge CLK) disable iff (RST | POR)
		(in_fso & pin_rise) |=> op_reg == fsm_pkg::ST_NORMAL && latched_reg == 3'h0;
	endproperty
	a_exit: assert property (p_exit) else $error("failsafe not left");
	property p_pins;
		@(posedge CLK) disable iff (RST | POR)
		(op_next != fsm_pkg::ST_NORMAL) |=> BUCK_ON == $past({ctrl_next[`FSM_BUCK1_BIT], ctrl_next[`FSM_BUCK2_BIT]});
	endproperty
	a_pins: assert property (p_pins) else $error("LED pins leaked in failsafe");
	property p_no_fso_otp;
		@(posedge CLK) disable iff (RST | POR)
		(~in_fso & gov == `FSM_MODE_OTP) |=> !in_fso;
	endproperty
	a_no_fso_otp: assert property (p_no_fso_otp) else $error("failsafe entered in mode 001");
endmodule : fsm_failsafe_ctrl
`default_nettype wire

// ==== rtl/fsm_params.svh ====
// Constants for the fail-safe mode controller and serial slave port.
// Assumes inclusion by bare name from rtl files.
`ifndef FSM_PARAMS_SVH
`define FSM_PARAMS_SVH
`define FSM_FRAME_BITS 16
`define FSM_CNT_W 5
`define FSM_MODE_W 3
`define FSM_MODE_ZERO 3'h0
`define FSM_MODE_OTP 3'h1
`define FSM_MODE_SA_LO 3'h6
`define FSM_CTRL_W 10
`define FSM_ADDR_W 4
`define FSM_ADDR_MODE 4'h4
`define FSM_MODE_LSB 4
`define FSM_BUCK1_BIT 1
`define FSM_BUCK2_BIT 0
`define FSM_CMD_BIT 15
`define FSM_PAR_BIT 10
`define FSM_ERR_REPLY 16'h8000
`endif

// ==== rtl/fsm_pkg.sv ====
// Types shared by the fail-safe mode controller files.
// Assumes fsm_params.svh is on the include path.
package fsm_pkg;
	typedef enum logic [1:0] {ST_NORMAL = 2'h0, ST_FAILSAFE = 2'h1, ST_STANDALONE = 2'h3} fsm_op_t;
	typedef struct packed {
		logic valid;
		logic [15:0] word;
		logic frame_err;
		logic daisy_req;
	} fsm_frame_t;
endpackage : fsm_pkg

// ==== rtl/fsm_spi_slave.sv ====
// Serial slave shifter on the SCLK domain; hands whole frames to CLK domain.
// Assumes mode 0 framing: sample on rise, drive on fall, chip select low.
`timescale 1ns/1ps
`default_nettype none
`include "fsm_params.svh"
module fsm_spi_slave (
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdi,
	input wire logic [15:0] reply,
	output logic sdo,
	output logic sdo_oe,
	output logic [15:0] rx_word,
	output logic rx_err,
	output logic rx_zero,
	output logic rx_toggle
);
	logic [15:0] sh_reg;
	logic [15:0] tx_reg;
	logic [`FSM_CNT_W-1:0] cnt_reg;
	logic ones_reg;
	logic toggle_reg;
	// Reply bits 14:0 are loaded at the fall after the first rise of each 16-bit slot
	wire logic first_bit = (cnt_reg[3:0] == 4'h1);
	// ==========================================
	// Receive on rising SCLK
	always_ff @(posedge sclk or posedge cs_n)
	begin
		if (cs_n)
		begin
			cnt_reg <= '0;
			ones_reg <= 1'b0;
		end
		else
		begin
			sh_reg <= {sh_reg[14:0], sdi};
			cnt_reg <= (cnt_reg[3:0] == 4'hF) ? 5'h10 : cnt_reg + 5'h01;
			ones_reg <= ones_reg | sdi;
		end
	end
	// ==========================================
	// Transmit on falling SCLK, first bit preloaded while selected idle
	always_ff @(negedge sclk or posedge cs_n)
	begin
		if (cs_n)
			tx_reg <= 16'h0000;
		else if (first_bit)
			tx_reg <= {reply[14:0], 1'b0};
		else
			tx_reg <= {tx_reg[14:0], 1'b0};
	end
	// ==========================================
	// Frame capture at chip select rise; the toggle starts from a known level
	always @(posedge cs_n)
	begin
		rx_word <= sh_reg;
		rx_err <= (cnt_reg == 5'h00) || (cnt_reg[3:0] != 4'h0);
		rx_zero <= ~ones_reg;
		toggle_reg <= ~toggle_reg;
	end
	initial toggle_reg = 1'b0;
	assign rx_toggle = toggle_reg;
	assign sdo = (cnt_reg == 5'h00) ? reply[15] : tx_reg[15];
	assign sdo_oe = ~cs_n;
endmodule : fsm_spi_slave
`default_nettype wire

// ==== rtl/fsm_sync.sv ====
// Two flip-flop synchroniser for a single level.
// Assumes an asynchronous level input and a free running clock.
`timescale 1ns/1ps
`default_nettype none
module fsm_sync (
	input wire logic clk,
	input wire logic d,
	output logic q
);
	logic meta_reg;
	always_ff @(posedge clk)
	begin
		meta_reg <= d;
		q <= meta_reg;
	end
endmodule : fsm_sync
`default_nettype wire

// ==== verification/failsafe_mode_and_serial_slave_test.sv ====
// Self-checking bench for the fail-safe controller and serial slave port.
// Assumes fsm_failsafe_ctrl and fsm_master_model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module failsafe_mode_and_serial_slave_test;
	logic CLK = 1'b0, RST = 1'b1, POR = 1'b1, EXT_RESET_PIN_N = 1'b1, OTP_LOCKED = 1'b1;
	logic [9:0] OTP_CTRL = 10'h0A2;
	logic [1:0] LED_CONTROL_PIN = 2'h0;
	logic SCLK, CHIP_SELECT_N, SDI, SDO, SDO_OE, FAILSAFE_OPERATION, STANDALONE_OPERATION;
	logic SERIAL_ERROR_FLAG, DAISY_CHAIN, DEVICE_RESET, seen;
	logic [9:0] CTRL_REGS;
	logic [1:0] BUCK_ON;
	logic [15:0] rep;
	wire logic sdo_bus;
	int bad_count = 0, checked = 0, k;
	typedef struct packed {logic [1:0] led; logic [1:0] buck;} fsm_row_t;
	fsm_row_t rows [4] = '{'{2'h0, 2'h0}, '{2'h1, 2'h1}, '{2'h2, 2'h2}, '{2'h3, 2'h3}};
	assign sdo_bus = SDO_OE ? SDO : 1'bz;
	always #2.5 CLK = ~CLK;
	fsm_failsafe_ctrl fsm_failsafe_ctrl_i (.CLK(CLK), .RST(RST), .POR(POR),
		.EXT_RESET_PIN_N(EXT_RESET_PIN_N), .OTP_LOCKED(OTP_LOCKED), .OTP_CTRL(OTP_CTRL),
		.LED_CONTROL_PIN(LED_CONTROL_PIN), .SCLK(SCLK), .CHIP_SELECT_N(CHIP_SELECT_N),
		.SDI(SDI), .SDO(SDO), .SDO_OE(SDO_OE), .CTRL_REGS(CTRL_REGS), .BUCK_ON(BUCK_ON),
		.FAILSAFE_OPERATION(FAILSAFE_OPERATION), .STANDALONE_OPERATION(STANDALONE_OPERATION),
		.SERIAL_ERROR_FLAG(SERIAL_ERROR_FLAG), .DAISY_CHAIN(DAISY_CHAIN),
		.DEVICE_RESET(DEVICE_RESET));
	fsm_master_model fsm_master_model_i (.sclk(SCLK), .cs_n(CHIP_SELECT_N), .sdi(SDI),
		.sdo_bus(sdo_bus));
	// ==========================================
	// Helpers
	task automatic stop_test();
		if (bad_count == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		checked++;
		if (s !== e)
		begin
			bad_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	function automatic logic [15:0] wr(input logic [3:0] a, input logic [9:0] d);
		logic [15:0] w;
		w = {1'b1, a, 1'b0, d};
		w[10] = ~(^w);
		return w;
	endfunction : wr
	task automatic send(input logic [15:0] w, input int n);
		fsm_master_model_i.xfer(w, n, rep);
		repeat (10) @(posedge CLK);
	endtask : send
	task automatic pin(input logic v);
		@(posedge CLK) EXT_RESET_PIN_N <= v;
		seen = 1'b0;
		repeat (10) @(posedge CLK) if (DEVICE_RESET === 1'b1) seen = 1'b1;
	endtask : pin
	task automatic do_rst(input logic [9:0] otp);
		@(posedge CLK) RST <= 1'b1;
		OTP_CTRL <= otp;
		repeat (3) @(posedge CLK);
		RST <= 1'b0;
		POR <= 1'b0;
		repeat (4) @(posedge CLK);
	endtask : do_rst
	// ==========================================
	// Tests
	initial
	begin
		#100000;
		bad_count++;
		stop_test();
	end
	initial
	begin
		do_rst(10'h0A2);
		chk(CTRL_REGS, 10'h000);
		chk(DAISY_CHAIN, 1'b0);
		chk(SDO_OE, 1'b0);
		send(wr(4'h1, 10'h383), 16);
		chk(rep, 16'h8000);
		chk(CTRL_REGS, 10'h383);
		send(wr(4'h1, 10'h383), 16);
		chk(rep, wr(4'h1, 10'h383));
		chk(SDO_OE, 1'b0);
		for (k = 0; k < 4; k++)
		begin
			@(posedge CLK) LED_CONTROL_PIN <= rows[k].led;
			repeat (6) @(posedge CLK);
			chk(BUCK_ON, rows[k].buck);
		end
		pin(1'b0);
		chk(seen, 1'b1);
		chk(CTRL_REGS, 10'h000);
		chk(FAILSAFE_OPERATION, 1'b0);
		pin(1'b1);
		send(wr(4'h1, 10'h383), 15);
		chk(SERIAL_ERROR_FLAG, 1'b1);
		// Blocking mode: pin entry, writes refused, errors still flagged
		do_rst(10'h0A2);
		send(wr(4'h4, 10'h020), 16);
		pin(1'b0);
		chk(FAILSAFE_OPERATION, 1'b1);
		chk(CTRL_REGS, 10'h0A2);
		chk(BUCK_ON, 2'h2);
		send(wr(4'h1, 10'h383), 16);
		chk(CTRL_REGS, 10'h0A2);
		chk(SERIAL_ERROR_FLAG, 1'b0);
		send(wr(4'h1, 10'h383) ^ 16'h0400, 16);
		chk(SERIAL_ERROR_FLAG, 1'b1);
		pin(1'b1);
		chk(FAILSAFE_OPERATION, 1'b0);
		// Writable mode: accepted update and exit by mode write
		do_rst(10'h0B3);
		send(wr(4'h4, 10'h030), 16);
		pin(1'b0);
		chk(FAILSAFE_OPERATION, 1'b1);
		@(posedge CLK) LED_CONTROL_PIN <= 2'h2;
		send(wr(4'h1, 10'h3B3), 16);
		chk(CTRL_REGS, 10'h3B3);
		chk(BUCK_ON, 2'h3);
		send(wr(4'h4, 10'h000), 16);
		chk(FAILSAFE_OPERATION, 1'b0);
		chk(BUCK_ON, 2'h2);
		pin(1'b1);
		send(16'h0000, 16);
		chk(DAISY_CHAIN, 1'b1);
		stop_test();
	end
endmodule : failsafe_mode_and_serial_slave_test
`default_nettype wire

// ==== verification/fsm_master_model.sv ====
// Serial master model for the fail-safe controller's slave port.
// Assumes the bench calls xfer and merges SDO with its enable onto sdo_bus.
`timescale 1ns/1ps
`default_nettype none
module fsm_master_model (
	output logic sclk,
	output logic cs_n,
	output logic sdi,
	input wire logic sdo_bus
);
	initial
	begin
		sclk = 1'b0;
		cs_n = 1'b1;
		sdi = 1'b0;
	end
	// ==========================================
	// Frame transfer, 30 ns clock only inside frames
	task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
		int i;
		r = '0;
		#7;
		cs_n = 1'b0;
		sdi = w[15];
		for (i = 0; i < n; i++)
		begin
			#15 sclk = 1'b1;
			r = {r[14:0], sdo_bus};
			#15 sclk = 1'b0;
			if (i < 15)
				sdi = w[14-i];
		end
		#15 cs_n = 1'b1;
		// Released line shows the inverse of its last value
		sdi = ~sdi;
		#40;
	endtask : xfer
endmodule : fsm_master_model
`default_nettype wire
